// ### mad_regs.svh
// constants for the memory address decoder: map boundaries and field positions
// assumes an 8-bit core that issues one access per accepted request
// Summary of operation
// - 256-byte internal data, upper half dual-mapped
// - indirect upper-half access reaches general RAM
// - direct upper-half access reaches special function space
// - lower half same bytes direct or indirect
// - bytes 0x00-0x1F form four register banks
// - bytes 0x20-0x2F byte and bit addressable
// - external moves reach 512-byte external data RAM
// - external addresses alias every 512 bytes
// - code below 0x1E00; 0x1E00-0x1FFF reserved
// - flash erased in 512-byte sectors in system
`ifndef MAD_REGS_SVH
`define MAD_REGS_SVH
`define MAD_IRAM_DEPTH 256
`define MAD_EXTERNAL_DATA_RAM_DEPTH 512
`define MAD_UPPER_BIT 7
`define MAD_BIT_BASE 8'h20
`define MAD_BIT_TOP 8'h2F
`define MAD_BANK_LSB 3
`define MAD_BANK_W 2
`define MAD_REG_W 3
`define MAD_CODE_RESV 16'h1E00
`define MAD_SECT_AW 9
`define MAD_ZERO8 8'h00
`endif

// ### mad_pkg.sv
// types shared by the decoder: access kinds and request, answer, target bundles
// assumes mad_regs.svh is on the include path
`include "mad_regs.svh"
package mad_pkg;
  typedef enum logic [2:0] {
    MAD_SP_DIRECT = 3'b000,
    MAD_SP_INDIRECT = 3'b001,
    MAD_SP_BIT = 3'b010,
    MAD_SP_REG = 3'b011,
    MAD_SP_XDATA = 3'b100,
    MAD_SP_CODE = 3'b101,
    MAD_SP_ERASE = 3'b110,
    MAD_SP_BAD = 3'b111
  } mad_space_t;

  typedef struct packed {
    logic valid;
    mad_space_t space;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mad_req_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic [7:0] rdata;
  } mad_rsp_t;

  typedef struct packed {
    logic valid;
    logic sel_flash;
    logic we;
    logic erase;
    logic bit_en;
    logic [2:0] bit_idx;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mad_ext_t;
endpackage

// ### mad_bit_unit.sv
// single-bit access helper: maps a bit address onto its byte and merges a bit
// assumes bit addresses below 0x80 land in the bit-addressable RAM bytes
`timescale 1ns/1ps
`include "mad_regs.svh"
module mad_bit_unit (
  input wire logic [7:0] i_bit_addr, // bit address from the core
  input wire logic [7:0] i_byte, // current content of the addressed byte
  input wire logic i_bit_val, // value to write into the bit
  output logic [7:0] o_byte_addr, // byte holding the bit
  output logic [2:0] o_bit_idx, // bit position within that byte
  output logic o_bit, // current value of the bit
  output logic [7:0] o_merged // byte with the bit replaced
);
  // sixteen bytes of eight bits cover bit addresses 0x00-0x7F
  always_comb
  begin
    o_byte_addr = `MAD_BIT_BASE + {4'h0, i_bit_addr[6:3]};
    o_bit_idx = i_bit_addr[2:0];
    o_bit = i_byte[i_bit_addr[2:0]];
    o_merged = i_byte;
    o_merged[i_bit_addr[2:0]] = i_bit_val;
  end
endmodule

// ### mad_decoder.sv
// memory address decoder: internal and external data RAM plus routing to
// special function space and program flash
// assumes special function and flash targets answer in the cycle of the strobe
`timescale 1ns/1ps
`include "mad_regs.svh"
module mad_decoder #(
  parameter int IRAM_DEPTH = `MAD_IRAM_DEPTH,
  parameter int EXTERNAL_DATA_RAM_DEPTH = `MAD_EXTERNAL_DATA_RAM_DEPTH
) (
  input wire logic i_core_clk, // system clock, 40 MHz
  input wire logic i_resetn, // asynchronous reset, active low
  input wire logic i_ce, // clock enable, freezes all state when low
  input wire mad_pkg::mad_req_t i_req, // access request from the core
  input wire logic [7:0] i_psw, // processor status word
  input wire logic [7:0] i_sfr_rdata, // special function read data
  input wire logic [7:0] i_flash_rdata, // flash read data
  output logic o_ready, // request can be taken this cycle if i_ce is high
  output mad_pkg::mad_rsp_t o_rsp, // answer to the core
  output mad_pkg::mad_ext_t o_ext // strobe toward sfr space or flash
);
  import mad_pkg::*;

  localparam int XAW = $clog2(EXTERNAL_DATA_RAM_DEPTH);

  typedef enum logic {
    MAD_ST_IDLE = 1'b0,
    MAD_ST_EXT = 1'b1
  } mad_state_t;

  mad_state_t state_q, state_d;
  mad_rsp_t rsp_q, rsp_d;
  mad_ext_t ext_q, ext_d;
  logic [7:0] iram_q [0:IRAM_DEPTH-1];
  logic [7:0] external_data_ram_q [0:EXTERNAL_DATA_RAM_DEPTH-1];
  logic acc;
  logic upper;
  logic [7:0] idx;
  logic iram_we;
  logic [7:0] iram_wdata;
  logic external_data_ram_we;
  logic [`MAD_BANK_W-1:0] bank;
  logic [7:0] bu_byte_addr;
  logic [2:0] bu_bit_idx;
  logic bu_bit;
  logic [7:0] bu_merged;

  // bank field of the status word picks which eight registers are live
  assign bank = i_psw[`MAD_BANK_LSB +: `MAD_BANK_W];
  assign upper = i_req.addr[`MAD_UPPER_BIT];
  assign acc = i_ce && i_req.valid && (state_q == MAD_ST_IDLE);
  // back-pressure only while an outside target is answering
  assign o_ready = (state_q == MAD_ST_IDLE);
  assign o_rsp = rsp_q;
  assign o_ext = ext_q;

  mad_bit_unit mad_bit_unit_i (
    .i_bit_addr(i_req.addr[7:0]),
    .i_byte(iram_q[bu_byte_addr]),
    .i_bit_val(i_req.wdata[0]),
    .o_byte_addr(bu_byte_addr),
    .o_bit_idx(bu_bit_idx),
    .o_bit(bu_bit),
    .o_merged(bu_merged)
  );

  // internal RAM index for each addressing style
  always_comb
  begin
    idx = i_req.addr[7:0];
    unique case (i_req.space)
      MAD_SP_REG: idx = {3'h0, bank, i_req.addr[`MAD_REG_W-1:0]};
      MAD_SP_BIT: idx = bu_byte_addr;
      default: idx = i_req.addr[7:0];
    endcase
  end

  // decode and next values; outside targets get a strobe and answer a cycle later
  always_comb
  begin
    state_d = state_q;
    rsp_d = rsp_q;
    ext_d = ext_q;
    iram_we = 1'b0;
    iram_wdata = i_req.wdata;
    external_data_ram_we = 1'b0;
    if (i_ce)
    begin
      rsp_d.valid = 1'b0;
      ext_d.valid = 1'b0;
      if (state_q == MAD_ST_EXT)
      begin
        // answer from the target strobed last cycle
        rsp_d.valid = 1'b1;
        rsp_d.err = 1'b0;
        rsp_d.rdata = ext_q.sel_flash ? i_flash_rdata : i_sfr_rdata;
        if (ext_q.bit_en)
          rsp_d.rdata = {7'h00, i_sfr_rdata[ext_q.bit_idx]};
        if (ext_q.we || ext_q.erase)
          rsp_d.rdata = `MAD_ZERO8;
        state_d = MAD_ST_IDLE;
      end
      else if (acc)
      begin
        rsp_d.valid = 1'b1;
        rsp_d.err = 1'b0;
        rsp_d.rdata = `MAD_ZERO8;
        ext_d = '0;
        ext_d.we = i_req.we;
        ext_d.wdata = i_req.wdata;
        ext_d.addr = i_req.addr;
        unique case (i_req.space)
          MAD_SP_DIRECT, MAD_SP_INDIRECT, MAD_SP_REG:
          begin
            if (i_req.space == MAD_SP_DIRECT && upper)
            begin
              // direct upper half never touches RAM
              ext_d.valid = 1'b1;
              ext_d.addr = {8'h00, i_req.addr[7:0]};
              rsp_d.valid = 1'b0;
              state_d = MAD_ST_EXT;
            end
            else
            begin
              iram_we = i_req.we;
              rsp_d.rdata = i_req.we ? `MAD_ZERO8 : iram_q[idx];
            end
          end
          MAD_SP_BIT:
          begin
            if (upper)
            begin
              // bit in a bit-addressable sfr: the target merges the bit itself
              ext_d.valid = 1'b1;
              ext_d.bit_en = 1'b1;
              ext_d.bit_idx = bu_bit_idx;
              ext_d.addr = {8'h00, i_req.addr[7:3], 3'h0};
              rsp_d.valid = 1'b0;
              state_d = MAD_ST_EXT;
            end
            else
            begin
              iram_we = i_req.we;
              iram_wdata = bu_merged;
              rsp_d.rdata = i_req.we ? `MAD_ZERO8 : {7'h00, bu_bit};
            end
          end
          MAD_SP_XDATA:
          begin
            // upper address bits ignored, so the RAM repeats every 512 bytes
            external_data_ram_we = i_req.we;
            rsp_d.rdata = i_req.we ? `MAD_ZERO8 : external_data_ram_q[i_req.addr[XAW-1:0]];
          end
          MAD_SP_CODE:
          begin
            if (i_req.addr < `MAD_CODE_RESV)
            begin
              ext_d.valid = 1'b1;
              ext_d.sel_flash = 1'b1;
              rsp_d.valid = 1'b0;
              state_d = MAD_ST_EXT;
            end
            else
              rsp_d.err = 1'b1;
          end
          MAD_SP_ERASE:
          begin
            // the top sector holds the reserved region and is refused whole
            if (i_req.addr < `MAD_CODE_RESV)
            begin
              ext_d.valid = 1'b1;
              ext_d.sel_flash = 1'b1;
              ext_d.erase = 1'b1;
              ext_d.we = 1'b0;
              ext_d.addr = {i_req.addr[15:`MAD_SECT_AW], {`MAD_SECT_AW{1'b0}}};
              rsp_d.valid = 1'b0;
              state_d = MAD_ST_EXT;
            end
            else
              rsp_d.err = 1'b1;
          end
          MAD_SP_BAD: rsp_d.err = 1'b1;
        endcase
      end
    end
  end

  // control state, reset to idle with no strobe or answer pending
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_q <= MAD_ST_IDLE;
      rsp_q <= '0;
      ext_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      rsp_q <= rsp_d;
      ext_q <= ext_d;
    end
  end

  // data arrays have no reset; contents are undefined until written
  always_ff @(posedge i_core_clk)
  begin
    if (iram_we)
      iram_q[idx] <= iram_wdata;
    if (external_data_ram_we)
      external_data_ram_q[i_req.addr[XAW-1:0]] <= i_req.wdata;
  end

  // helper copies of the previous cycle's request, read or write, for the checks below
  logic [7:0] chk_idx_q;
  logic [7:0] chk_dat_q;
  logic [XAW-1:0] chk_xidx_q;
  logic [7:0] chk_bbyte_q;
  logic [2:0] chk_bpos_q;
  always_ff @(posedge i_core_clk)
  begin
    chk_idx_q <= {3'h0, bank, i_req.addr[`MAD_REG_W-1:0]};
    chk_dat_q <= i_req.wdata;
    chk_xidx_q <= i_req.addr[XAW-1:0];
    chk_bbyte_q <= bu_byte_addr;
    chk_bpos_q <= bu_bit_idx;
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  chk_upper_indirect_ram: assert property (
    acc && i_req.space == MAD_SP_INDIRECT && upper |=> o_rsp.valid && !o_ext.valid)
    else $error("indirect upper access left internal RAM");
  chk_upper_direct_sfr: assert property (
    acc && i_req.space == MAD_SP_DIRECT && upper
      |=> o_ext.valid && !o_ext.sel_flash && o_ext.addr[7:0] == $past(i_req.addr[7:0])
      ##1 o_rsp.valid)
    else $error("direct upper access not routed to sfr space");
  chk_lower_ram: assert property (
    acc && i_req.space == MAD_SP_DIRECT && !upper |=> o_rsp.valid && !o_ext.valid)
    else $error("direct lower access did not hit RAM");
  chk_reg_bank: assert property (
    acc && i_req.space == MAD_SP_REG && i_req.we |=> iram_q[chk_idx_q] == chk_dat_q)
    else $error("register write missed the selected bank");
  chk_bit_area: assert property (
    i_req.space == MAD_SP_BIT && !upper
      |-> bu_byte_addr >= `MAD_BIT_BASE && bu_byte_addr <= `MAD_BIT_TOP)
    else $error("bit address mapped outside the bit area");
  // the written bit must really land in the byte that holds it
  chk_bit_write: assert property (
    acc && i_req.space == MAD_SP_BIT && !upper && i_req.we
      |=> iram_q[chk_bbyte_q][chk_bpos_q] == chk_dat_q[0])
    else $error("bit write did not land in its byte");
  chk_external_data_ram_alias: assert property (
    acc && i_req.space == MAD_SP_XDATA && i_req.we |=> external_data_ram_q[chk_xidx_q] == chk_dat_q)
    else $error("external data write did not land at its alias");
  chk_code_reserved: assert property (
    acc && i_req.space == MAD_SP_CODE && i_req.addr >= `MAD_CODE_RESV
      |=> o_rsp.valid && o_rsp.err && !o_ext.valid)
    else $error("reserved code region was not refused");
  chk_erase_sector: assert property (
    acc && i_req.space == MAD_SP_ERASE && i_req.addr < `MAD_CODE_RESV
      |=> o_ext.valid && o_ext.erase && o_ext.addr[`MAD_SECT_AW-1:0] == '0 && !o_ready)
    else $error("erase not issued on a sector boundary");
endmodule

// ### mad_target_model.sv
// far-side target model: special function space and program flash
// assumes strobes from mad_decoder and a combinational answer in the strobe cycle
`timescale 1ns/1ps
module mad_target_model (
  input wire logic i_core_clk, // system clock
  input wire mad_pkg::mad_ext_t i_ext, // strobe from the decoder
  output logic [7:0] o_sfr_rdata, // special function read data
  output logic [7:0] o_flash_rdata, // flash read data
  output logic [15:0] o_erase_addr // base of the last erased sector
);
  import mad_pkg::*;
  logic [7:0] sfr_q [128];
  logic [7:0] last_q = 8'h00;
  initial o_erase_addr = 16'hFFFF;
  // idle lines show the inverse of the last answer so a stale value never matches
  always_comb
  begin
    o_sfr_rdata = ~last_q;
    o_flash_rdata = ~last_q;
    if (i_ext.valid && !i_ext.sel_flash)
      o_sfr_rdata = sfr_q[i_ext.addr[6:0]];
    if (i_ext.valid && i_ext.sel_flash)
      o_flash_rdata = i_ext.addr[7:0] ^ 8'hA5;
  end
  // writes and erases land on the strobe edge
  always @(posedge i_core_clk)
    if (i_ext.valid)
    begin
      last_q <= i_ext.sel_flash ? o_flash_rdata : o_sfr_rdata;
      if (!i_ext.sel_flash && i_ext.we)
        sfr_q[i_ext.addr[6:0]] <= i_ext.wdata;
      if (i_ext.erase)
        o_erase_addr <= i_ext.addr;
    end
endmodule

// ### tb_top.sv
// self-checking bench for mad_decoder with a target model on its far side
// assumes the core side is driven 1 ns after each rising edge
`timescale 1ns/1ps
module tb_top;
  import mad_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_resetn = 1'b0;
  mad_req_t req = '0;
  logic [7:0] psw = 8'h00;
  logic ce = 1'b1;
  logic [7:0] sfr_rd;
  logic [7:0] fl_rd;
  logic [15:0] erase_addr;
  logic ready;
  mad_rsp_t rsp;
  mad_ext_t ext;
  int n_errors = 0;
  int n_compared = 0;
  mad_decoder mad_decoder_i (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_ce(ce),
    .i_req(req), .i_psw(psw), .i_sfr_rdata(sfr_rd), .i_flash_rdata(fl_rd),
    .o_ready(ready), .o_rsp(rsp), .o_ext(ext));
  mad_target_model mad_target_model_i (.i_core_clk(i_core_clk), .i_ext(ext),
    .o_sfr_rdata(sfr_rd), .o_flash_rdata(fl_rd), .o_erase_addr(erase_addr));
  initial
  begin
    forever #12.5 i_core_clk = ~i_core_clk;
  end
  // closing report, also reached when a wait runs out
  task automatic results();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(string n, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // one whole access: hold the request until taken, then wait a bounded time for the answer
  task automatic acc(mad_space_t sp, logic we, logic [15:0] a, logic [7:0] d,
    output mad_rsp_t r);
    int k;
    req = '{1'b1, sp, we, a, d};
    k = 0;
    @(negedge i_core_clk);
    while (ready !== 1'b1 && k < 8)
    begin
      @(negedge i_core_clk);
      k++;
    end
    // a request never taken leaves no answer and ends the run below
    if (ready === 1'b1)
    begin
      @(posedge i_core_clk);
      #1 req.valid = 1'b0;
      k = 0;
      @(negedge i_core_clk);
      while (rsp.valid !== 1'b1 && k < 4)
      begin
        @(negedge i_core_clk);
        k++;
      end
    end
    r = rsp;
    if (rsp.valid !== 1'b1)
    begin
      n_errors++;
      $display("CHECK FAILED answer expected 1 seen %b", rsp.valid);
      results();
    end
    else
    begin
      @(posedge i_core_clk);
      #1;
    end
  endtask
  task automatic wr(mad_space_t sp, logic [15:0] a, logic [7:0] d);
    mad_rsp_t r;
    acc(sp, 1'b1, a, d, r);
  endtask
  // e is {err, rdata}; read data is ignored when e expects an error
  task automatic rd(string n, mad_space_t sp, logic [15:0] a, logic [8:0] e);
    mad_rsp_t r;
    acc(sp, 1'b0, a, 8'h00, r);
    check(n, 16'(e), {7'h00, r.err, e[8] ? 8'h00 : r.rdata});
  endtask
  task automatic sc_lower();
    wr(MAD_SP_DIRECT, 16'h0045, 8'h3C);
    rd("ind45", MAD_SP_INDIRECT, 16'h0045, 9'h03C);
    wr(MAD_SP_INDIRECT, 16'h007F, 8'hC3);
    rd("dir7F", MAD_SP_DIRECT, 16'h007F, 9'h0C3);
  endtask
  task automatic sc_upper();
    wr(MAD_SP_INDIRECT, 16'h0090, 8'h11);
    wr(MAD_SP_DIRECT, 16'h0090, 8'h22);
    wr(MAD_SP_INDIRECT, 16'h00FF, 8'h33);
    rd("ind90", MAD_SP_INDIRECT, 16'h0090, 9'h011);
    rd("dir90", MAD_SP_DIRECT, 16'h0090, 9'h022);
    rd("indFF", MAD_SP_INDIRECT, 16'h00FF, 9'h033);
  endtask
  // a request met by a busy decoder waits; a low clock enable freezes the answer
  task automatic sc_hold();
    req = '{1'b1, MAD_SP_DIRECT, 1'b0, 16'h0090, 8'h00};
    @(posedge i_core_clk);
    #1 req = '{1'b1, MAD_SP_INDIRECT, 1'b0, 16'h0045, 8'h00};
    @(negedge i_core_clk);
    check("busy_ready", 16'h0000, {15'h0000, ready});
    @(negedge i_core_clk);
    check("sfr_rd", 16'h0122, {7'h00, rsp.valid, rsp.rdata});
    @(posedge i_core_clk);
    #1 ce = 1'b0;
    req = '{1'b1, MAD_SP_INDIRECT, 1'b0, 16'h0090, 8'h00};
    @(negedge i_core_clk);
    check("held_rd", 16'h013C, {7'h00, rsp.valid, rsp.rdata});
    repeat (2) @(posedge i_core_clk);
    @(negedge i_core_clk);
    check("frozen", 16'h033C, {6'h00, ready, rsp.valid, rsp.rdata});
    @(posedge i_core_clk);
    #1 ce = 1'b1;
    @(posedge i_core_clk);
    #1 req.valid = 1'b0;
    @(negedge i_core_clk);
    check("thawed_rd", 16'h0111, {7'h00, rsp.valid, rsp.rdata});
    @(posedge i_core_clk);
    #1;
  endtask
  // register 7 of every bank, bank 3 ends on the last register byte
  task automatic sc_banks();
    for (int b = 0; b < 4; b++)
    begin
      psw = {3'b000, 2'(b), 3'b000};
      wr(MAD_SP_REG, 16'h0007, 8'(8'h50 + b));
      rd("bank", MAD_SP_DIRECT, 16'(8 * b + 7), 9'(8'h50 + b));
    end
  endtask
  task automatic sc_bits();
    wr(MAD_SP_DIRECT, 16'h002F, 8'h00);
    wr(MAD_SP_BIT, 16'h007F, 8'h01);
    rd("byte2F", MAD_SP_DIRECT, 16'h002F, 9'h080);
    rd("bit7F", MAD_SP_BIT, 16'h007F, 9'h001);
    rd("bit7E", MAD_SP_BIT, 16'h007E, 9'h000);
    wr(MAD_SP_DIRECT, 16'h0020, 8'hFE);
    rd("bit00", MAD_SP_BIT, 16'h0000, 9'h000);
  endtask
  task automatic sc_xdata();
    wr(MAD_SP_DIRECT, 16'h0003, 8'h5A);
    wr(MAD_SP_XDATA, 16'h0003, 8'h77);
    wr(MAD_SP_XDATA, 16'h01FF, 8'h88);
    rd("x0203", MAD_SP_XDATA, 16'h0203, 9'h077);
    rd("xFFFF", MAD_SP_XDATA, 16'hFFFF, 9'h088);
    rd("dir03", MAD_SP_DIRECT, 16'h0003, 9'h05A);
  endtask
  task automatic sc_code();
    mad_rsp_t r;
    rd("c1DFF", MAD_SP_CODE, 16'h1DFF, {1'b0, 8'hFF ^ 8'hA5});
    rd("c1E00", MAD_SP_CODE, 16'h1E00, 9'h100);
    rd("e1E00", MAD_SP_ERASE, 16'h1E00, 9'h100);
    rd("bad", MAD_SP_BAD, 16'h0000, 9'h100);
    acc(MAD_SP_ERASE, 1'b0, 16'h0345, 8'h00, r);
    check("erase_err", 16'h0000, {15'h0000, r.err});
    check("erase_base", 16'h0200, erase_addr);
  endtask
  initial
  begin
    repeat (10) @(posedge i_core_clk);
    #1 i_resetn = 1'b1;
    @(posedge i_core_clk);
    #1;
    sc_lower();
    sc_upper();
    sc_hold();
    sc_banks();
    sc_bits();
    sc_xdata();
    sc_code();
    results();
  end
endmodule
